/* design/bsd_fifo.sv */
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes one clock; width and depth are parameters, depth a power of two.
*/
`default_nettype none

module bsd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0] wrPtr_r;
  logic [PW:0] rdPtr_r;
  logic doPush;
  logic doPop;

  assign inReady = (wrPtr_r - rdPtr_r) != (PW + 1)'(DEPTH);
  assign outValid = wrPtr_r != rdPtr_r;
  assign outData = mem[rdPtr_r[PW-1:0]];
  assign doPush = inValid && inReady;
  assign doPop = outValid && outReady;

  always_ff @(posedge mclk) begin
    if (doPush) begin
      mem[wrPtr_r[PW-1:0]] <= inData;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wrPtr_r <= '0;
    end else if (doPush) begin
      wrPtr_r <= wrPtr_r + 1'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdPtr_r <= '0;
    end else if (doPop) begin
      rdPtr_r <= rdPtr_r + 1'h1;
    end
  end

endmodule : bsd_fifo

`default_nettype wire

/* design/bsd_pin_watch.sv */
/*
  Pin watcher: three-stage synchroniser, filtered level, rise pulse and a
  still flag once the level has not changed for STILL_CYC cycles.
  Assumes the pin is asynchronous to mclk.
*/
`default_nettype none

module bsd_pin_watch #(
  parameter int STILL_CYC = 2
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // raw pin
  input wire logic pinIn,
  // filtered view
  output logic level,
  output logic rise,
  output logic still
);

  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic level_r;
  logic [7:0] stillCnt_r;
  logic primed_r;
  logic change;

  always_ff @(posedge mclk) begin
    s1_r <= pinIn;
    s2_r <= s1_r;
    s3_r <= s2_r;
  end

  // a change counts only once stages two and three agree
  assign change = (s2_r == s3_r) && (s3_r != level_r);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      level_r <= 1'h0;
    end else if (change) begin
      level_r <= s3_r;
    end
  end

  // first agreed level after reset is no edge: pins may idle high or low
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      primed_r <= 1'h0;
    end else if (s2_r == s3_r) begin
      primed_r <= 1'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n || change) begin
      stillCnt_r <= 8'h00;
    end else if (stillCnt_r != 8'hff) begin
      stillCnt_r <= stillCnt_r + 8'h01;
    end
  end

  assign level = level_r;
  assign rise = change && s3_r && primed_r;
  assign still = (32'(stillCnt_r) >= STILL_CYC);

endmodule : bsd_pin_watch

`default_nettype wire

/* design/bsd_pkg.sv */
/*
  Shared constants, state encodings and carrier types for the burst-of-two
  SRAM core with its delay-loop start-up control.
  Assumes one 40 MHz system clock (mclk) that samples every pin.
*/
`default_nettype none

package bsd_pkg;

  localparam int DATA_W = 18;
  localparam int ADDR_W = 8;
  localparam int CLK_PERIOD_NS = 25;
  localparam int STOP_NS = 30;
  // least time: round up to whole mclk cycles
  localparam int STOP_CYC = (STOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOCK_CYC = 2048;
  localparam int LOCK_W = 12;
  localparam int FIFO_DEPTH = 16;
  localparam int SLOT_N = 4;
  // output ticks counted after the command edge: t+0.5 is tick 1
  localparam int SLOT_NORMAL = 3;
  localparam int SLOT_BYPASS = 2;
  localparam int PIN_K = 0;
  localparam int PIN_KN = 1;
  localparam int PIN_C = 2;
  localparam int PIN_CN = 3;
  localparam int PIN_BYPASS = 4;
  localparam int PIN_N = 5;

  typedef enum logic [1:0] {
    BSD_INIT_COUNT = 2'b00,
    BSD_INIT_READY = 2'b01
  } bsd_init_t;

  typedef enum logic [1:0] {
    BSD_WR_IDLE = 2'b00,
    BSD_WR_HALF = 2'b01,
    BSD_WR_PUSH = 2'b10
  } bsd_wr_state_t;

  typedef struct packed {
    logic readSelN;
    logic writeSelN;
    logic [ADDR_W-1:0] rdAddr;
    logic [ADDR_W-1:0] wrAddr;
    logic [DATA_W-1:0] dataIn;
  } bsd_bus_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] word0;
    logic [DATA_W-1:0] word1;
  } bsd_wr_t;

  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] data;
  } bsd_slot_t;

endpackage : bsd_pkg

`default_nettype wire

/* design/bsd_top.sv */
/*
  Burst-of-two SRAM core: start-up and delay-loop lock control, independent
  read and write machines, two-word linear bursts, output word timing.
  Assumes every pin (clock pairs, selects, addresses, data) is sampled by
  mclk and that the main clock pair toggles faster than the still limit.
*/
`default_nettype none

module bsd_top #(
  parameter int LOCK_CYC = bsd_pkg::LOCK_CYC,
  parameter int STILL_CYC = bsd_pkg::STOP_CYC,
  parameter int DEPTH = bsd_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // clock pins
  input wire logic kClk,
  input wire logic kClkN,
  input wire logic oClk,
  input wire logic oClkN,
  input wire logic bypassN,
  // command and data pins
  input wire logic readSelN,
  input wire logic writeSelN,
  input wire logic [bsd_pkg::ADDR_W-1:0] rdAddr,
  input wire logic [bsd_pkg::ADDR_W-1:0] wrAddr,
  input wire logic [bsd_pkg::DATA_W-1:0] dataIn,
  // read data
  output logic [bsd_pkg::DATA_W-1:0] dataOut,
  output logic dataOutEn,
  // status
  output logic ready,
  output logic dllLocked,
  output logic readBusy,
  output logic writeBusy
);

  localparam int AW = bsd_pkg::ADDR_W;
  localparam int DW = bsd_pkg::DATA_W;
  localparam int WRW = $bits(bsd_pkg::bsd_wr_t);

  // pin sampling
  bsd_pkg::bsd_bus_t busS1_r;
  bsd_pkg::bsd_bus_t busS2_r;
  bsd_pkg::bsd_bus_t bus_r;
  logic [bsd_pkg::PIN_N-1:0] pinRaw;
  logic [bsd_pkg::PIN_N-1:0] pinLevel;
  logic [bsd_pkg::PIN_N-1:0] pinRise;
  logic [bsd_pkg::PIN_N-1:0] pinStill;

  // start-up and loop control
  bsd_pkg::bsd_init_t initState_r;
  bsd_pkg::bsd_init_t initState_nxt;
  logic [bsd_pkg::LOCK_W-1:0] lockCnt_r;
  logic loopReset;
  logic bypass;
  logic kRise;
  logic knRise;

  // commands
  logic rdCmd;
  logic wrCmd;

  // write path
  bsd_pkg::bsd_wr_state_t wrState_r;
  bsd_pkg::bsd_wr_t wrEntry_r;
  logic fifoInReady;
  logic fifoOutValid;
  logic fifoOutReady;
  logic [WRW-1:0] fifoOutRaw;
  bsd_pkg::bsd_wr_t fifoOut;
  logic drainSecond_r;

  // array
  logic [DW-1:0] mem [2 ** (AW + 1)];

  // read path
  bsd_pkg::bsd_slot_t pipe_r [1:bsd_pkg::SLOT_N];
  bsd_pkg::bsd_slot_t pipe_nxt [1:bsd_pkg::SLOT_N];
  logic singleClock;
  logic outTick;

  // output registers
  logic [DW-1:0] dataOut_r;
  logic dataOutEn_r;
  logic ready_r;
  logic dllLocked_r;
  logic readBusy_r;
  logic writeBusy_r;

  // array index of burst step; the step is the low address bit
  function automatic logic [AW:0] burstIndex(input logic [AW-1:0] base,
                                             input logic step);
    burstIndex = {base, step};
  endfunction : burstIndex

  // bus pins pass three stages so they line up with the clock watchers
  always_ff @(posedge mclk) begin
    busS1_r <= '{readSelN, writeSelN, rdAddr, wrAddr, dataIn};
    busS2_r <= busS1_r;
    bus_r <= busS2_r;
  end

  assign pinRaw = {bypassN, oClkN, oClk, kClkN, kClk};

  genvar gi;
  generate
    for (gi = 0; gi < bsd_pkg::PIN_N; gi++) begin : g_pin
      bsd_pin_watch #(
        .STILL_CYC(STILL_CYC)
      ) u_watch (
        .mclk(mclk),
        .rst_n(rst_n),
        .pinIn(pinRaw[gi]),
        .level(pinLevel[gi]),
        .rise(pinRise[gi]),
        .still(pinStill[gi])
      );
    end
  endgenerate

  // sequencing is timed by main clock rises only
  assign kRise = pinRise[bsd_pkg::PIN_K];
  assign knRise = pinRise[bsd_pkg::PIN_KN];
  assign bypass = !pinLevel[bsd_pkg::PIN_BYPASS];

  // a stopped clock phase or a bypass release restarts locking
  assign loopReset = pinStill[bsd_pkg::PIN_K] || pinStill[bsd_pkg::PIN_KN]
    || pinRise[bsd_pkg::PIN_BYPASS];

  always_comb begin
    initState_nxt = initState_r;
    case (initState_r)
      bsd_pkg::BSD_INIT_COUNT: begin
        // bypass changes latency and holds dllLocked low; the interval is still waited out
        if (kRise && 32'(lockCnt_r) >= LOCK_CYC - 1) begin
          initState_nxt = bsd_pkg::BSD_INIT_READY;
        end
      end
      bsd_pkg::BSD_INIT_READY: begin
        initState_nxt = bsd_pkg::BSD_INIT_READY;
      end
      default: begin
        initState_nxt = bsd_pkg::BSD_INIT_COUNT;
      end
    endcase
    if (loopReset) begin
      initState_nxt = bsd_pkg::BSD_INIT_COUNT;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      initState_r <= bsd_pkg::BSD_INIT_COUNT;
    end else begin
      initState_r <= initState_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n || loopReset) begin
      lockCnt_r <= '0;
    end else if (initState_r == bsd_pkg::BSD_INIT_COUNT && kRise) begin
      lockCnt_r <= lockCnt_r + 1'h1;
    end
  end

  // commands are only honoured once ready
  assign rdCmd = ready_r && kRise && !bus_r.readSelN;
  assign wrCmd = ready_r && kRise && !bus_r.writeSelN;

  // write machine: word0 at the K rise, address and word1 at the K# rise
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wrState_r <= bsd_pkg::BSD_WR_IDLE;
    end else begin
      case (wrState_r)
        bsd_pkg::BSD_WR_IDLE: begin
          if (wrCmd) begin
            wrState_r <= bsd_pkg::BSD_WR_HALF;
          end
        end
        bsd_pkg::BSD_WR_HALF: begin
          if (knRise) begin
            wrState_r <= bsd_pkg::BSD_WR_PUSH;
          end else if (wrCmd) begin
            wrState_r <= bsd_pkg::BSD_WR_HALF;
          end
        end
        bsd_pkg::BSD_WR_PUSH: begin
          // a new command while the buffer is full replaces the entry
          if (fifoInReady) begin
            wrState_r <= wrCmd ? bsd_pkg::BSD_WR_HALF : bsd_pkg::BSD_WR_IDLE;
          end else if (wrCmd) begin
            wrState_r <= bsd_pkg::BSD_WR_HALF;
          end
        end
        default: begin
          wrState_r <= bsd_pkg::BSD_WR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wrEntry_r <= '0;
    end else if (wrCmd) begin
      wrEntry_r.word0 <= bus_r.dataIn;
    end else if (wrState_r == bsd_pkg::BSD_WR_HALF && knRise) begin
      wrEntry_r.addr <= bus_r.wrAddr;
      wrEntry_r.word1 <= bus_r.dataIn;
    end
  end

  bsd_fifo #(
    .WIDTH(WRW),
    .DEPTH(DEPTH)
  ) u_wbuf (
    .mclk(mclk),
    .rst_n(rst_n),
    .inValid(wrState_r == bsd_pkg::BSD_WR_PUSH),
    .inReady(fifoInReady),
    .inData(wrEntry_r),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOutRaw)
  );

  assign fifoOut = bsd_pkg::bsd_wr_t'(fifoOutRaw);
  // single array port: a read command takes it, the drain waits
  assign fifoOutReady = drainSecond_r && !rdCmd;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      drainSecond_r <= 1'h0;
    end else if (fifoOutValid && !rdCmd) begin
      drainSecond_r <= !drainSecond_r;
    end
  end

  always_ff @(posedge mclk) begin
    if (fifoOutValid && !rdCmd) begin
      mem[burstIndex(fifoOut.addr, drainSecond_r)] <=
        drainSecond_r ? fifoOut.word1 : fifoOut.word0;
    end
  end

  // output clocks both held high: main clock pair times the outputs
  assign singleClock = pinLevel[bsd_pkg::PIN_C] && pinLevel[bsd_pkg::PIN_CN]
    && pinStill[bsd_pkg::PIN_C] && pinStill[bsd_pkg::PIN_CN];
  assign outTick = singleClock ? (kRise || knRise)
    : (pinRise[bsd_pkg::PIN_C] || pinRise[bsd_pkg::PIN_CN]);

  // read pipe advances one slot per output edge; reads are independent
  always_comb begin
    for (int i = 1; i <= bsd_pkg::SLOT_N; i++) begin
      pipe_nxt[i] = pipe_r[i];
    end
    if (outTick) begin
      for (int i = 1; i < bsd_pkg::SLOT_N; i++) begin
        pipe_nxt[i] = pipe_r[i + 1];
      end
      pipe_nxt[bsd_pkg::SLOT_N] = '0;
    end
    if (rdCmd) begin
      if (bypass) begin
        pipe_nxt[bsd_pkg::SLOT_BYPASS] = '{1'h1, mem[burstIndex(bus_r.rdAddr, 1'h0)]};
        pipe_nxt[bsd_pkg::SLOT_BYPASS + 1] =
          '{1'h1, mem[burstIndex(bus_r.rdAddr, 1'h1)]};
      end else begin
        pipe_nxt[bsd_pkg::SLOT_NORMAL] = '{1'h1, mem[burstIndex(bus_r.rdAddr, 1'h0)]};
        pipe_nxt[bsd_pkg::SLOT_NORMAL + 1] =
          '{1'h1, mem[burstIndex(bus_r.rdAddr, 1'h1)]};
      end
    end
  end

  // a later no-op never clears slots already loaded
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      for (int i = 1; i <= bsd_pkg::SLOT_N; i++) begin
        pipe_r[i] <= '0;
      end
    end else begin
      for (int i = 1; i <= bsd_pkg::SLOT_N; i++) begin
        pipe_r[i] <= pipe_nxt[i];
      end
    end
  end

  // outputs move only on output edges, so a stopped clock holds them
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      dataOut_r <= '0;
      dataOutEn_r <= 1'h0;
    end else if (outTick) begin
      dataOutEn_r <= pipe_r[1].valid;
      if (pipe_r[1].valid) begin
        dataOut_r <= pipe_r[1].data;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ready_r <= 1'h0;
      dllLocked_r <= 1'h0;
    end else begin
      ready_r <= initState_nxt == bsd_pkg::BSD_INIT_READY;
      dllLocked_r <= initState_nxt == bsd_pkg::BSD_INIT_READY && !bypass;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      readBusy_r <= 1'h0;
      writeBusy_r <= 1'h0;
    end else begin
      readBusy_r <= pipe_nxt[1].valid || pipe_nxt[2].valid
        || pipe_nxt[3].valid || pipe_nxt[4].valid;
      writeBusy_r <= wrState_r != bsd_pkg::BSD_WR_IDLE || fifoOutValid;
    end
  end

  assign dataOut = dataOut_r;
  assign dataOutEn = dataOutEn_r;
  assign ready = ready_r;
  assign dllLocked = dllLocked_r;
  assign readBusy = readBusy_r;
  assign writeBusy = writeBusy_r;

endmodule : bsd_top

`default_nettype wire

/* tb/bsd_ctrl_model.sv */
/*
  Controller clock model: K/K# with a 4 mclk period, C/C# in phase.
  Assumes run and single are set by the bench.
*/
`default_nettype none

module bsd_ctrl_model (
  // control
  input wire logic mclk,
  input wire logic run,
  input wire logic single,
  // clock pins
  output var logic kClk,
  output var logic kClkN,
  output logic oClk,
  output logic oClkN
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] phase = 2'h0;
  initial begin
    kClk = 1'b0;
    kClkN = 1'b1;
  end
  // stopped clock holds its level so the still detector can see it
  always @(posedge mclk) begin
    #1;
    if (run) begin
      phase = phase + 2'h1;
      kClk = phase[1];
      kClkN = ~phase[1];
    end
  end
  assign oClk = single | kClk;
  assign oClkN = single | kClkN;
endmodule : bsd_ctrl_model

`default_nettype wire

/* tb/bsd_sva.sv */
/*
  Port checker for bsd_top, bound into every instance.
  Assumes the single mclk domain and the pin delays of the core.
*/
`default_nettype none

module bsd_sva #(
  parameter int LOCK_CYC = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // pins
  input wire logic kClk,
  input wire logic bypassN,
  input wire logic readSelN,
  input wire logic writeSelN,
  // outputs
  input wire logic [bsd_pkg::DATA_W-1:0] dataOut,
  input wire logic dataOutEn,
  input wire logic ready,
  input wire logic dllLocked,
  input wire logic readBusy,
  input wire logic writeBusy
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // raw rises lead filtered ones, so one spare rise is allowed
  logic [15:0] kRiseCnt;
  always_ff @(posedge mclk) begin
    if (!rst_n || ready) kRiseCnt <= 16'h0000;
    else if ($rose(kClk)) kRiseCnt <= kRiseCnt + 16'h0001;
  end
  // consecutive cycles with no read while ready, saturating at 16
  logic [4:0] idleCnt_r;
  always_ff @(posedge mclk) begin
    if (!rst_n || !readSelN || !ready) idleCnt_r <= 5'h00;
    else if (idleCnt_r != 5'h10) idleCnt_r <= idleCnt_r + 5'h01;
  end
  a_reset_clears: assert property (disable iff (1'b0) !rst_n |=> !ready && !dataOutEn)
    else $error("output active after reset");
  a_lock_count: assert property ($rose(ready) |-> kRiseCnt + 16'h0001 >= LOCK_CYC)
    else $error("ready before lock interval");
  a_lock_flag: assert property (dllLocked |-> ready)
    else $error("locked while not ready");
  a_bypass_reset: assert property ($rose(bypassN) && ready |-> ##[1:6] !ready)
    else $error("bypass rise kept ready");
  a_stop_reset: assert property (ready ##0 $stable(kClk) [*3] |-> ##[0:6] !ready)
    else $error("stopped clock kept ready");
  a_read_taken: assert property (ready && !readSelN && $rose(kClk) |-> ##[2:6] readBusy)
    else $error("read not taken");
  a_write_taken: assert property (ready && !writeSelN && $rose(kClk) |-> ##[2:8] writeBusy)
    else $error("write not taken");
  a_word_pair: assert property ($rose(dataOutEn) |-> dataOutEn [*4])
    else $error("burst shorter than two words");
  a_data_stands: assert property (dataOutEn && $changed(dataOut) |=> $stable(dataOut))
    else $error("read word changed between ticks");
  a_output_float: assert property (idleCnt_r == 5'h10 |-> !dataOutEn)
    else $error("outputs driven without reads");
endmodule : bsd_sva

bind bsd_top bsd_sva #(.LOCK_CYC(LOCK_CYC)) uSva (.mclk, .rst_n, .kClk, .bypassN, .readSelN,
  .writeSelN, .dataOut, .dataOutEn, .ready, .dllLocked, .readBusy, .writeBusy);

`default_nettype wire

/* tb/tb.sv */
/*
  Self-checking bench for bsd_top with a shortened lock interval.
  Assumes the clock model in bsd_ctrl_model and the bound checker.
*/
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LOCK = 8;
  logic mclk, rst_n, bypassN, readSelN, writeSelN, run, single;
  logic kClk, kClkN, oClk, oClkN, dataOutEn, ready, dllLocked, readBusy, writeBusy;
  logic [bsd_pkg::ADDR_W-1:0] rdAddr, wrAddr;
  logic [bsd_pkg::DATA_W-1:0] dataIn, dataOut;
  int miscompares = 0;
  int checked = 0;
  int latNorm;

  bsd_ctrl_model uCtrl (.mclk, .run, .single, .kClk, .kClkN, .oClk, .oClkN);
  bsd_top #(.LOCK_CYC(LOCK)) DUT (.mclk, .rst_n, .kClk, .kClkN, .oClk, .oClkN, .bypassN,
    .readSelN, .writeSelN, .rdAddr, .wrAddr, .dataIn, .dataOut, .dataOutEn, .ready,
    .dllLocked, .readBusy, .writeBusy);

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc

  task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic timed_out(input string what);
    miscompares++;
    $display("CHECK FAILED %s expected done seen timeout", what);
    end_sim();
  endtask : timed_out

  // bounded wait for a raw rise of K (n = 0) or K# (n = 1)
  task automatic k_edge(input logic n);
    bit seen;
    seen = 1'b0;
    fork
      begin
        if (n) @(posedge kClkN);
        else @(posedge kClk);
        seen = 1'b1;
      end
      repeat (8) @(posedge mclk);
    join_any
    disable fork;
    if (!seen) timed_out("clock edge");
  endtask : k_edge

  // counts raw K rises until ready, so the lock interval can be judged
  task automatic wait_ready(output int rises);
    logic kOld;
    rises = 0;
    kOld = kClk;
    for (int n = 0; n < 400 && ready !== 1'b1; n++) begin
      cyc(1);
      if (kClk && !kOld) rises++;
      kOld = kClk;
    end
    if (ready !== 1'b1) timed_out("ready");
  endtask : wait_ready

  task automatic wait_drain;
    cyc(4);
    for (int n = 0; n < 200 && writeBusy !== 1'b0; n++) cyc(1);
    if (writeBusy !== 1'b0) timed_out("drain");
  endtask : wait_drain

  task automatic do_write(input logic [7:0] a, input logic [17:0] w0, input logic [17:0] w1);
    k_edge(1'b0);
    writeSelN = 1'b0;
    dataIn = w0;
    k_edge(1'b1);
    writeSelN = 1'b1;
    wrAddr = a;
    dataIn = w1;
  endtask : do_write

  task automatic do_read(input logic [7:0] a, input logic [17:0] w0, input logic [17:0] w1,
    output int lat);
    k_edge(1'b0);
    readSelN = 1'b0;
    rdAddr = a;
    k_edge(1'b1);
    readSelN = 1'b1;
    for (lat = 2; lat < 30 && dataOutEn !== 1'b1; lat++) cyc(1);
    if (dataOutEn !== 1'b1) timed_out("read data");
    check("word0", dataOut, w0);
    cyc(2);
    check("word1", dataOut, w1);
    cyc(2);
    check("float", dataOutEn, 1'b0);
    check("read idle", readBusy, 1'b0);
  endtask : do_read

  task automatic test_lock;
    int r;
    wait_ready(r);
    check("lock rises", r + 1 >= LOCK, 1'b1);
    check("locked", dllLocked, 1'b1);
    $display("test lock done");
  endtask : test_lock

  task automatic test_burst;
    int lat;
    do_write(8'h10, 18'h0_1234, 18'h2_abcd);
    do_write(8'h11, 18'h1_0f0f, 18'h3_0001);
    wait_drain();
    do_read(8'h10, 18'h0_1234, 18'h2_abcd, latNorm);
    fork
      do_read(8'h11, 18'h1_0f0f, 18'h3_0001, lat);
      do_write(8'h20, 18'h0_5555, 18'h0_aaaa);
    join
    wait_drain();
    do_read(8'h20, 18'h0_5555, 18'h0_aaaa, lat);
    $display("test burst done");
  endtask : test_burst

  // stop right after the word0 tick so word1 never gets its tick
  task automatic test_stop;
    int r;
    k_edge(1'b0);
    readSelN = 1'b0;
    rdAddr = 8'h10;
    k_edge(1'b1);
    readSelN = 1'b1;
    k_edge(1'b0);
    k_edge(1'b1);
    run = 1'b0;
    cyc(8);
    check("held data", dataOut, 18'h0_1234);
    check("held enable", dataOutEn, 1'b1);
    check("stop reset", ready, 1'b0);
    run = 1'b1;
    wait_ready(r);
    check("relock rises", r + 1 >= LOCK, 1'b1);
    $display("test stop done");
  endtask : test_stop

  task automatic test_bypass;
    int lat;
    int r;
    bypassN = 1'b0;
    cyc(8);
    do_read(8'h10, 18'h0_1234, 18'h2_abcd, lat);
    check("bypass gain", latNorm - lat, 2);
    check("bypass unlocked", dllLocked, 1'b0);
    bypassN = 1'b1;
    for (int n = 0; n < 8 && ready === 1'b1; n++) cyc(1);
    check("bypass reset", ready, 1'b0);
    wait_ready(r);
    check("relocked", dllLocked, 1'b1);
    $display("test bypass done");
  endtask : test_bypass

  task automatic test_single;
    int lat;
    single = 1'b1;
    cyc(8);
    do_read(8'h11, 18'h1_0f0f, 18'h3_0001, lat);
    check("single latency", lat, latNorm);
    single = 1'b0;
    $display("test single done");
  endtask : test_single

  initial begin
    rst_n = 1'b0;
    bypassN = 1'b1;
    readSelN = 1'b1;
    writeSelN = 1'b1;
    rdAddr = 8'h00;
    wrAddr = 8'h00;
    dataIn = 18'h0_0000;
    run = 1'b1;
    single = 1'b0;
    cyc(2);
    rst_n = 1'b1;
    test_lock();
    test_burst();
    test_stop();
    test_bypass();
    test_single();
    end_sim();
  end
endmodule : tb

`default_nettype wire
